// ===== logic/fpi_pkg.sv
// Package: shared constants, types and state codes for fault supervision
package fpi_pkg;
  // Clock and timing
  localparam int SYS_CLK_NS = 10;
  localparam int SCP_BLANK_NS = 4000000;
  localparam int SCP_BLANK_CYC = (SCP_BLANK_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

  // Register offsets
  localparam logic [7:0] MODE_CONTROL_OFS = 8'h01;
  localparam logic [7:0] FAULT_FLAG_OFS = 8'h02;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h03;

  // Reset values
  localparam logic [7:0] MODE_CONTROL_RST = 8'h00;
  localparam logic [4:0] FAULT_FLAG_RST = 5'h00;
  localparam logic [4:0] IRQ_MASK_RST = 5'h00;

  // Mode control fields; bit 7 is reserved and reads zero
  localparam int MODE_STBY_BIT = 5;
  localparam int MODE_NOGDWN_BIT = 3;
  localparam logic [7:0] MODE_WR_MASK = 8'h7f;

  // Flag and mask field positions
  localparam int FLAG_W = 5;
  localparam int FLG_LIGHT = 0;
  localparam int FLG_OVP = 1;
  localparam int FLG_HOT = 2;
  localparam int FLG_SHORT = 3;
  localparam int FLG_LIGHT2 = 4;

  // Charge-pump gain codes
  localparam logic [1:0] GAIN_1X = 2'h0;
  localparam logic [1:0] GAIN_2X = 2'h2;

  // Sequencer states
  typedef enum logic [4:0] {
    ST_OFF = 5'h01,
    ST_SOFT = 5'h02,
    ST_RUN = 5'h04,
    ST_SHORT = 5'h08,
    ST_HOT = 5'h10
  } fpi_state_t;

  // Analog fault indications
  typedef struct packed {
    logic short_ind;
    logic ovp_high;
    logic ovp_low;
    logic overtemp;
    logic clamp;
  } fpi_sense_t;

  // Drive outputs to the analog power stage
  typedef struct packed {
    logic pump_en;
    logic sinks_en;
    logic core_on;
    logic rout_raise;
    logic low_power;
    logic [1:0] gain;
  } fpi_drive_t;
endpackage : fpi_pkg

// ===== logic/fpi_fault_seq.sv
// Fault sequencer: standby, soft start, run, short and thermal shutdown
`timescale 1ns/1ps
module fpi_fault_seq #(
  parameter int BLANK_CYC = fpi_pkg::SCP_BLANK_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Requests from the register file
  input wire logic start_req,
  input wire logic stop_req,
  // Fault indications
  input wire logic short_ind,
  input wire logic overtemp_ind,
  // Status
  output fpi_pkg::fpi_state_t state,
  output logic pump_active,
  output logic scp_enter,
  output logic tsd_enter
);
  import fpi_pkg::*;

  localparam int TW = (BLANK_CYC > 1) ? $clog2(BLANK_CYC) : 1;
  localparam logic [TW-1:0] TIMER_LAST = TW'(BLANK_CYC - 1);

  generate
    if (BLANK_CYC < 1) begin : g_bad_blank
      $error("BLANK_CYC must be at least one cycle");
    end
  endgenerate

  fpi_state_t state_reg;
  fpi_state_t state_next;
  logic [TW-1:0] timer_reg;
  logic [TW-1:0] timer_next;

  // Next state; overtemperature overrides every other path
  always_comb begin
    state_next = state_reg;
    timer_next = timer_reg;
    unique case (state_reg)
      ST_OFF: begin
        if (start_req) begin
          state_next = ST_SOFT;
          timer_next = '0;
        end
      end
      ST_SOFT: begin
        if (stop_req) begin
          state_next = ST_OFF;
        end else if (timer_reg == TIMER_LAST) begin
          state_next = ST_RUN;
        end else begin
          timer_next = timer_reg + TW'(1);
        end
      end
      ST_RUN: begin
        if (stop_req) begin
          state_next = ST_OFF;
        end else if (short_ind) begin
          state_next = ST_SHORT;
        end
      end
      ST_SHORT, ST_HOT: begin
        if (start_req) begin
          state_next = ST_SOFT;
          timer_next = '0;
        end
      end
    endcase
    if (overtemp_ind) begin
      state_next = ST_HOT;
    end
  end

  // State registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_reg <= ST_OFF;
      timer_reg <= '0;
    end else begin
      state_reg <= state_next;
      timer_reg <= timer_next;
    end
  end

  // Short sensing only in run, so startup and restarts are blind
  assign state = state_reg;
  assign pump_active = (state_reg == ST_SOFT) || (state_reg == ST_RUN);
  assign scp_enter = (state_reg == ST_RUN) && short_ind && !stop_req && !overtemp_ind;
  assign tsd_enter = overtemp_ind && (state_reg != ST_HOT);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_soft_start;
    (state_reg == ST_OFF || state_reg == ST_SHORT || state_reg == ST_HOT) && start_req && !overtemp_ind;
  endsequence

  property p_short_ignored_soft;
    (state_reg == ST_SOFT) && !overtemp_ind |=> (state_reg != ST_SHORT);
  endproperty
  a_short_ignored_soft: assert property (p_short_ignored_soft) else $error("short acted on during soft start");

  property p_restart_soft;
    s_soft_start |=> (state_reg == ST_SOFT) && (timer_reg == '0);
  endproperty
  a_restart_soft: assert property (p_restart_soft) else $error("restart did not begin a soft start");

  property p_hot_no_self_restart;
    (state_reg == ST_HOT) && !start_req |=> (state_reg == ST_HOT);
  endproperty
  a_hot_no_self_restart: assert property (p_hot_no_self_restart) else $error("left thermal shutdown alone");

  property p_blank_length;
    (state_reg == ST_SOFT) && (timer_reg == TIMER_LAST) && !stop_req && !overtemp_ind |=> (state_reg == ST_RUN);
  endproperty
  a_blank_length: assert property (p_blank_length) else $error("short sensing not re-enabled on time");
endmodule : fpi_fault_seq

// ===== logic/fpi_fault_irq.sv
// Fault protection and interrupt logic for a charge-pump LED driver
`timescale 1ns/1ps
module fpi_fault_irq #(
  parameter int BLANK_CYC = fpi_pkg::SCP_BLANK_CYC,
  parameter int SINKS = 7
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic uvlo_ind,
  // Register port behind the two-wire interface
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Analog fault indications
  input fpi_pkg::fpi_sense_t sense,
  // Light-sensor threshold outputs, bit 1 dark, bit 0 office
  input wire logic [1:0] light_main,
  input wire logic [1:0] light_second,
  // Current-sink headroom evaluation
  input wire logic gain_eval,
  input wire logic [SINKS-1:0] sink_on,
  input wire logic [SINKS-1:0] headroom_low,
  input wire logic [SINKS-1:0] headroom_high,
  // Power stage drive and interrupt pin
  output fpi_pkg::fpi_drive_t drive,
  output logic irq_out_n
);
  import fpi_pkg::*;

  generate
    if (SINKS < 1) begin : g_bad_sinks
      $error("SINKS must be at least one");
    end
  endgenerate

  logic rst;
  logic wr_mode;
  logic wr_flag;
  logic wr_mask;
  logic start_req;
  logic stop_req;
  logic pump_active;
  logic scp_enter;
  logic tsd_enter;
  logic ovp_enter;
  logic [1:0] light_change;
  logic [FLAG_W-1:0] flag_set;
  fpi_state_t state;

  logic [7:0] mode_control_reg;
  logic [7:0] mode_control_next;
  logic [FLAG_W-1:0] fault_flag_reg;
  logic [FLAG_W-1:0] fault_flag_next;
  logic [FLAG_W-1:0] irq_mask_reg;
  logic [FLAG_W-1:0] irq_mask_next;
  logic ovp_mode_reg;
  logic ovp_mode_next;
  logic [1:0] gain_reg;
  logic [1:0] gain_next;
  logic [1:0] light_prev_reg [2];
  logic [1:0] light_prev_next [2];
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  fpi_drive_t drive_reg;
  fpi_drive_t drive_next;

  // Undervoltage acts as a reset of every register
  assign rst = reset || uvlo_ind;

  // Register write decode
  assign wr_mode = reg_wr && (reg_addr == MODE_CONTROL_OFS);
  assign wr_flag = reg_wr && (reg_addr == FAULT_FLAG_OFS);
  assign wr_mask = reg_wr && (reg_addr == IRQ_MASK_OFS);

  // Each write of one to the release bit is a start request
  assign start_req = wr_mode && reg_wdata[MODE_STBY_BIT];
  assign stop_req = !mode_control_reg[MODE_STBY_BIT];

  fpi_fault_seq #(
    .BLANK_CYC(BLANK_CYC)
  ) u_seq (
    .sys_clk(sys_clk),
    .reset(rst),
    .start_req(start_req),
    .stop_req(stop_req),
    .short_ind(sense.short_ind),
    .overtemp_ind(sense.overtemp),
    .state(state),
    .pump_active(pump_active),
    .scp_enter(scp_enter),
    .tsd_enter(tsd_enter)
  );

  // Edge detection on both threshold outputs of both sensors
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_light
      logic [1:0] light_now;
      assign light_now = (gi == 0) ? light_main : light_second;
      assign light_prev_next[gi] = light_now;
      assign light_change[gi] = |(light_now ^ light_prev_reg[gi]);
    end
  endgenerate

  // Overvoltage entry while the pump runs
  assign ovp_enter = pump_active && !ovp_mode_reg && sense.ovp_high;

  // Hardware set sources for the flag register
  always_comb begin
    flag_set = '0;
    flag_set[FLG_LIGHT] = light_change[0];
    flag_set[FLG_LIGHT2] = light_change[1];
    flag_set[FLG_OVP] = ovp_enter;
    flag_set[FLG_HOT] = sense.overtemp;
    flag_set[FLG_SHORT] = scp_enter;
  end

  // Next values of the register file; hardware set beats a clear
  always_comb begin
    mode_control_next = mode_control_reg;
    irq_mask_next = irq_mask_reg;
    if (wr_mode) begin
      mode_control_next = reg_wdata & MODE_WR_MASK;
    end
    if (scp_enter || tsd_enter) begin
      mode_control_next[MODE_STBY_BIT] = 1'b0;
    end
    if (wr_mask) begin
      irq_mask_next = reg_wdata[FLAG_W-1:0];
    end
    fault_flag_next = fault_flag_reg;
    if (wr_flag) begin
      fault_flag_next = fault_flag_reg & ~reg_wdata[FLAG_W-1:0];
    end
    fault_flag_next = fault_flag_next | flag_set;
  end

  // Overvoltage hysteresis and automatic gain selection
  always_comb begin
    ovp_mode_next = ovp_mode_reg;
    if (!pump_active) begin
      ovp_mode_next = 1'b0;
    end else if (ovp_enter) begin
      ovp_mode_next = 1'b1;
    end else if (ovp_mode_reg && sense.ovp_low) begin
      ovp_mode_next = 1'b0;
    end
    gain_next = gain_reg;
    if (!pump_active || !(|sink_on)) begin
      gain_next = GAIN_1X;
    end else if (gain_eval) begin
      if (|(headroom_low & sink_on) && (gain_reg != GAIN_2X)) begin
        gain_next = gain_reg + 2'h1;
      end else if (((headroom_high | ~sink_on) == '1) && !mode_control_reg[MODE_NOGDWN_BIT] &&
                   (gain_reg != GAIN_1X)) begin
        gain_next = gain_reg - 2'h1;
      end
    end
  end

  // Drive outputs and read data
  always_comb begin
    drive_next.pump_en = pump_active && !ovp_mode_next;
    drive_next.sinks_en = pump_active;
    drive_next.core_on = (state != ST_HOT) && !tsd_enter;
    drive_next.rout_raise = pump_active && sense.clamp;
    drive_next.low_power = (state == ST_SHORT) || (state == ST_HOT) || (state == ST_OFF);
    drive_next.gain = gain_next;
    rdata_next = rdata_reg;
    if (reg_rd) begin
      unique case (reg_addr)
        MODE_CONTROL_OFS: rdata_next = mode_control_reg;
        FAULT_FLAG_OFS: rdata_next = {3'h0, fault_flag_reg};
        IRQ_MASK_OFS: rdata_next = {3'h0, irq_mask_reg};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // Registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_control_reg <= MODE_CONTROL_RST;
      fault_flag_reg <= FAULT_FLAG_RST;
      irq_mask_reg <= IRQ_MASK_RST;
      ovp_mode_reg <= 1'b0;
      gain_reg <= GAIN_1X;
      light_prev_reg[0] <= light_prev_next[0]; // Level present at reset is no edge
      light_prev_reg[1] <= light_prev_next[1];
      rdata_reg <= 8'h00;
      drive_reg <= '0;
    end else begin
      mode_control_reg <= mode_control_next;
      fault_flag_reg <= fault_flag_next;
      irq_mask_reg <= irq_mask_next;
      ovp_mode_reg <= ovp_mode_next;
      gain_reg <= gain_next;
      light_prev_reg[0] <= light_prev_next[0];
      light_prev_reg[1] <= light_prev_next[1];
      rdata_reg <= rdata_next;
      drive_reg <= drive_next;
    end
  end

  // Interrupt pin from masked flags, active low
  assign irq_out_n = !(|(fault_flag_reg & irq_mask_reg));
  assign drive = drive_reg;
  assign reg_rdata = rdata_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_irq_level;
    (|(fault_flag_reg & irq_mask_reg)) == !irq_out_n;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt pin disagrees with masked flags");

  property p_mask_gates;
    (irq_mask_reg == '0) |-> irq_out_n;
  endproperty
  a_mask_gates: assert property (p_mask_gates) else $error("interrupt with all sources masked");

  property p_w1c;
    wr_flag && reg_wdata[FLG_OVP] && !flag_set[FLG_OVP] |=> !fault_flag_reg[FLG_OVP];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write of one did not clear flag");

  property p_zero_write_keeps;
    (wr_flag && (reg_wdata[FLAG_W-1:0] == '0)) || (reg_rd && !reg_wr) |=>
      fault_flag_reg == ($past(fault_flag_reg) | $past(flag_set));
  endproperty
  a_zero_write_keeps: assert property (p_zero_write_keeps) else $error("flag changed on read or zero write");

  property p_short_flag;
    scp_enter |=> fault_flag_reg[FLG_SHORT] && (state == ST_SHORT) ##1 drive_reg.low_power;
  endproperty
  a_short_flag: assert property (p_short_flag) else $error("short entry without flag or low power");

  property p_ovp_pump_off;
    ovp_enter |=> !drive_reg.pump_en && drive_reg.sinks_en;
  endproperty
  a_ovp_pump_off: assert property (p_ovp_pump_off) else $error("overvoltage did not stop only the pump");

  property p_ovp_flag_each;
    ovp_enter |=> fault_flag_reg[FLG_OVP];
  endproperty
  a_ovp_flag_each: assert property (p_ovp_flag_each) else $error("overvoltage entry without flag");

  property p_hot_resets_flag;
    sense.overtemp |=> fault_flag_reg[FLG_HOT];
  endproperty
  a_hot_resets_flag: assert property (p_hot_resets_flag) else $error("thermal flag not held while hot");

  property p_no_stepdown;
    mode_control_reg[MODE_NOGDWN_BIT] && pump_active && (|sink_on) && !$past(wr_mode) |=> gain_reg >= $past(gain_reg);
  endproperty
  a_no_stepdown: assert property (p_no_stepdown) else $error("gain lowered with stepdown disabled");

  property p_clamp_no_flag;
    sense.clamp && !sense.ovp_high && !sense.overtemp && !scp_enter && !(|light_change) && !(|fault_flag_reg) &&
      !wr_flag |=> (fault_flag_reg == '0);
  endproperty
  a_clamp_no_flag: assert property (p_clamp_no_flag) else $error("clamp regulation raised a flag");

  property p_no_cool_irq;
    !sense.overtemp && !fault_flag_reg[FLG_HOT] |=> !fault_flag_reg[FLG_HOT];
  endproperty
  a_no_cool_irq: assert property (p_no_cool_irq) else $error("thermal flag raised while cool");

  property p_ovp_resume;
    ovp_mode_reg && sense.ovp_low && pump_active |=> drive_reg.pump_en;
  endproperty
  a_ovp_resume: assert property (p_ovp_resume) else $error("pump did not resume after overvoltage");

  property p_hot_shutdown;
    tsd_enter |=> !drive_reg.core_on && (state == ST_HOT) && !mode_control_reg[MODE_STBY_BIT];
  endproperty
  a_hot_shutdown: assert property (p_hot_shutdown) else $error("thermal entry did not shut down");

  property p_light_flag;
    light_change[0] |=> fault_flag_reg[FLG_LIGHT];
  endproperty
  a_light_flag: assert property (p_light_flag) else $error("light change without flag");
endmodule : fpi_fault_irq

// ===== tb/fpi_host_model.sv
// Host processor model driving the register strobe port
`timescale 1ns/1ps
module fpi_host_model (
  // Clock
  input wire logic sys_clk,
  // Register port
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  import fpi_pkg::*;

  // Idle port at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end

  // One write, held across its taking edge
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge sys_clk);
    #1;
    reg_addr = addr;
    reg_wdata = data;
    reg_wr = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~data;  // Released data stops showing the last value
  endtask : write_reg

  // One read, answer taken one cycle after the strobe
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(posedge sys_clk);
    #1;
    reg_addr = addr;
    reg_rd = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~addr;
    data = reg_rdata;
  endtask : read_reg

  // Standby release, also used as restart after faults
  task automatic start_device;
    write_reg(MODE_CONTROL_OFS, 8'h20);
  endtask : start_device

  // Board with small fly capacitors keeps gain from stepping down
  task automatic set_small_fly_caps;
    write_reg(MODE_CONTROL_OFS, 8'h28);
  endtask : set_small_fly_caps
endmodule : fpi_host_model

// ===== tb/fpi_fault_irq_bench.sv
// Self-checking bench for the fault protection and interrupt logic
`timescale 1ns/1ps
module fpi_fault_irq_bench;
  import fpi_pkg::*;
  localparam int BLANK = 8;
  logic sys_clk;
  logic reset;
  logic uvlo_ind;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic [7:0] reg_wdata;
  logic reg_rd;
  logic [7:0] reg_rdata;
  fpi_sense_t sense;
  logic [1:0] light_main;
  logic [1:0] light_second;
  logic gain_eval;
  logic [6:0] sink_on;
  logic [6:0] headroom_low;
  logic [6:0] headroom_high;
  fpi_drive_t drive;
  logic irq_out_n;
  logic [1:0] g;
  int num_errors = 0;
  int samples_checked = 0;

  fpi_fault_irq #(.BLANK_CYC(BLANK), .SINKS(7)) u_dut (
    .sys_clk(sys_clk), .reset(reset), .uvlo_ind(uvlo_ind), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sense(sense), .light_main(light_main),
    .light_second(light_second), .gain_eval(gain_eval), .sink_on(sink_on), .headroom_low(headroom_low),
    .headroom_high(headroom_high), .drive(drive), .irq_out_n(irq_out_n)
  );

  fpi_host_model u_host (
    .sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata)
  );

  // Clock generation
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Helpers: cycle stepping, compare, register compare, gain strobe
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic rd_check(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    u_host.read_reg(addr, d);
    check(d, exp);
  endtask : rd_check

  task automatic pulse_eval;
    gain_eval = 1'b1;
    step(1);
    gain_eval = 1'b0;
    step(2);
  endtask : pulse_eval

  task automatic complete_run;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  // Watchdog against a hung sequence
  initial begin
    repeat (5000) @(posedge sys_clk);
    num_errors++;
    complete_run();
  end

  // Main test sequence
  initial begin
    reset = 1'b1;
    uvlo_ind = 1'b0;
    sense = '0;
    light_main = 2'b00;
    light_second = 2'b00;
    gain_eval = 1'b0;
    sink_on = 7'h00;
    headroom_low = 7'h00;
    headroom_high = 7'h00;
    step(10);
    reset = 1'b0;
    // Defaults and unmapped address
    rd_check(MODE_CONTROL_OFS, 8'h00);
    rd_check(FAULT_FLAG_OFS, 8'h00);
    rd_check(IRQ_MASK_OFS, 8'h00);
    rd_check(8'h07, 8'h00);
    check({7'h00, irq_out_n}, 8'h01);
    // Light flags, pin gating and clearing
    light_main = 2'b01;
    step(3);
    check({7'h00, irq_out_n}, 8'h01);
    rd_check(FAULT_FLAG_OFS, 8'h01);
    u_host.write_reg(FAULT_FLAG_OFS, 8'h00);
    rd_check(FAULT_FLAG_OFS, 8'h01);
    u_host.write_reg(IRQ_MASK_OFS, 8'hff);
    rd_check(IRQ_MASK_OFS, 8'h1f);
    check({7'h00, irq_out_n}, 8'h00);
    u_host.write_reg(FAULT_FLAG_OFS, 8'h01);
    check({7'h00, irq_out_n}, 8'h01);
    rd_check(FAULT_FLAG_OFS, 8'h00);
    light_main = 2'b11;
    step(3);
    rd_check(FAULT_FLAG_OFS, 8'h01);
    u_host.write_reg(FAULT_FLAG_OFS, 8'h01);
    light_main = 2'b00;
    step(3);
    rd_check(FAULT_FLAG_OFS, 8'h01);
    u_host.write_reg(FAULT_FLAG_OFS, 8'h01);
    light_second = 2'b10;
    step(3);
    rd_check(FAULT_FLAG_OFS, 8'h10);
    u_host.write_reg(FAULT_FLAG_OFS, 8'h10);
    // Start with a short during soft start
    sink_on = 7'h7f;
    u_host.start_device();
    sense.short_ind = 1'b1;
    step(4);
    sense.short_ind = 1'b0;
    check({7'h00, drive.pump_en}, 8'h01);
    rd_check(FAULT_FLAG_OFS, 8'h00);
    step(BLANK);
    // Clamp regulation raises output resistance silently
    sense.clamp = 1'b1;
    step(3);
    check({7'h00, drive.rout_raise}, 8'h01);
    sense.clamp = 1'b0;
    rd_check(FAULT_FLAG_OFS, 8'h00);
    // Two overvoltage episodes
    repeat (2) begin
      sense.ovp_high = 1'b1;
      step(3);
      check({7'h00, drive.pump_en}, 8'h00);
      check({7'h00, drive.sinks_en}, 8'h01);
      sense.ovp_high = 1'b0;
      sense.ovp_low = 1'b1;
      step(3);
      sense.ovp_low = 1'b0;
      check({7'h00, drive.pump_en}, 8'h01);
      rd_check(FAULT_FLAG_OFS, 8'h02);
      u_host.write_reg(FAULT_FLAG_OFS, 8'h02);
    end
    // Gain selection with and without step-down lock
    headroom_low = 7'h01;
    pulse_eval();
    check({7'h00, drive.gain > GAIN_1X}, 8'h01);
    g = drive.gain;
    u_host.set_small_fly_caps();
    headroom_low = 7'h00;
    headroom_high = 7'h7f;
    pulse_eval();
    check({6'h00, drive.gain}, {6'h00, g});
    u_host.start_device();
    headroom_high = 7'h3f;
    pulse_eval();
    check({6'h00, drive.gain}, {6'h00, g});
    headroom_high = 7'h7f;
    pulse_eval();
    check({7'h00, drive.gain < g}, 8'h01);
    // Output short in run, then restart
    sense.short_ind = 1'b1;
    step(3);
    sense.short_ind = 1'b0;
    check({7'h00, drive.low_power}, 8'h01);
    check({7'h00, drive.pump_en}, 8'h00);
    check({7'h00, irq_out_n}, 8'h00);
    rd_check(FAULT_FLAG_OFS, 8'h08);
    rd_check(MODE_CONTROL_OFS, 8'h00);
    u_host.write_reg(FAULT_FLAG_OFS, 8'h08);
    u_host.start_device();
    sense.short_ind = 1'b1;
    step(3);
    sense.short_ind = 1'b0;
    check({7'h00, drive.pump_en}, 8'h01);
    rd_check(FAULT_FLAG_OFS, 8'h00);
    step(BLANK);
    // Overtemperature, clear while hot, cool down, host restart
    sense.overtemp = 1'b1;
    step(3);
    check({7'h00, drive.core_on}, 8'h00);
    check({7'h00, drive.pump_en}, 8'h00);
    u_host.write_reg(FAULT_FLAG_OFS, 8'h04);
    rd_check(FAULT_FLAG_OFS, 8'h04);
    sense.overtemp = 1'b0;
    step(2);
    u_host.write_reg(FAULT_FLAG_OFS, 8'h04);
    step(5);
    rd_check(FAULT_FLAG_OFS, 8'h00);
    check({7'h00, irq_out_n}, 8'h01);
    check({7'h00, drive.pump_en}, 8'h00);
    u_host.start_device();
    step(2);
    check({7'h00, drive.pump_en}, 8'h01);
    // Undervoltage restores defaults
    uvlo_ind = 1'b1;
    step(2);
    uvlo_ind = 1'b0;
    check({7'h00, drive.pump_en}, 8'h00);
    rd_check(IRQ_MASK_OFS, 8'h00);
    rd_check(MODE_CONTROL_OFS, 8'h00);
    rd_check(FAULT_FLAG_OFS, 8'h00);
    complete_run();
  end
endmodule : fpi_fault_irq_bench
